/* File: bench/core_model.sv */
// behavioural model of the processor core taking vectors from the controller
`timescale 1ns/1ps
module core_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       vector_valid,
   input  wire logic [7:0] ack_delay,
   output logic            vector_ack,
   output logic            service_done
);
   // ****************************************
   // take vector, run a short routine, return
   // ****************************************
   initial begin
      vector_ack   = 1'b0;
      service_done = 1'b0;
      forever begin
         @(posedge pclk);
         if (presetn === 1'b1 && vector_valid === 1'b1) begin
            // a slow core leaves the vector standing for a while
            repeat (ack_delay) @(posedge pclk);
            vector_ack <= 1'b1;
            @(posedge pclk);
            vector_ack <= 1'b0;
            repeat (20) @(posedge pclk);
            service_done <= 1'b1;
            @(posedge pclk);
            service_done <= 1'b0;
         end
      end
   end
endmodule : core_model

/* File: bench/paired_priority_interrupt_controller_bench.sv */
// self-checking bench of the paired priority interrupt controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
module paired_priority_interrupt_controller_bench;
   import irq_ctrl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0]  pin_n;
   logic [4:0]  ev;
   logic        vector_ack, service_done, vector_valid, err;
   logic [15:0] vector_addr;
   logic [3:0]  vector_source;
   logic [7:0]  ack_delay;
   int          mismatches, samples_checked, cycles;

   paired_priority_interrupt_controller u_dut (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_request_pin_0(pin_n[0]), .ext_request_pin_1(pin_n[1]),
      .ext_request_pin_2(pin_n[2]), .ext_request_pin_3(pin_n[3]),
      .ext_request_pin_4(pin_n[4]), .ext_request_pin_5(pin_n[5]),
      .ext_request_pin_6(pin_n[6]), .timer0_event(ev[0]), .timer1_event(ev[1]),
      .timer2_event(ev[2]), .serial_event(ev[3]), .adc_event(ev[4]),
      .vector_ack(vector_ack), .service_done(service_done), .vector_valid(vector_valid),
      .vector_addr(vector_addr), .vector_source(vector_source));
   core_model u_core (
      .pclk(pclk), .presetn(presetn), .vector_valid(vector_valid), .ack_delay(ack_delay),
      .vector_ack(vector_ack), .service_done(service_done));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task summarize;
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         summarize();
      end
   end

   // ****************************************
   // apb master: hold request until pready
   // ****************************************
   task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task reg_check(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK("register read", {24'h0, exp}, rd)
      `CHK("register error", 1'b0, err)
   endtask : reg_check

   // pin index of an external source; 7 means an internal event
   function automatic int pin_of(input int s);
      case (s)
         SRC_EXT0: return 0;  SRC_EXT1: return 1;  SRC_EXT2: return 2;
         SRC_EXT3: return 3;  SRC_EXT4: return 4;  SRC_EXT5: return 5;
         SRC_EXT6: return 6;  default: return 7;
      endcase
   endfunction : pin_of

   function automatic int ev_of(input int s);
      case (s)
         SRC_TMR0: return 0;  SRC_TMR1: return 1;  SRC_TMR2: return 2;
         SRC_SER: return 3;   default: return 4;
      endcase
   endfunction : ev_of

   // level sources hold the pin low until the vector shows
   task fire(input int s, input bit level);
      if (pin_of(s) < 7) begin
         pin_n[pin_of(s)] <= 1'b0;
         repeat (40) @(posedge pclk);
         if (!level) pin_n[pin_of(s)] <= 1'b1;
      end else begin
         ev[ev_of(s)] <= 1'b1;
         @(posedge pclk);
         ev <= 5'h00;
      end
   endtask : fire

   // wait for a vector, judge source, address and delay, then let the core serve it
   task vec(input logic [3:0] s, input int min_clks);
      int n;
      n = 0;
      while (vector_valid !== 1'b1 && n < 1200) begin
         @(posedge pclk);
         n++;
      end
      `CHK("vector source", s, vector_source)
      `CHK("vector address", VECTOR_BASE + (16'(s) << VECTOR_SHIFT), vector_addr)
      `CHK("response delay", 1'b1, n >= min_clks && n <= 8 * MCYCLE_CLKS + 8)
      pin_n <= 7'h7F;
      n = 0;
      while (service_done !== 1'b1 && n < 600) begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
   endtask : vec

   // ****************************************
   // scenarios
   // ****************************************
   task reset_and_map;
      reg_check(ADDR_SOURCE_ENABLE_A, 8'h00);
      reg_check(ADDR_SOURCE_ENABLE_B, 8'h00);
      reg_check(ADDR_PRIORITY_A, 8'h00);
      reg_check(ADDR_PRIORITY_B, 8'h00);
      apb(1'b0, 12'h010, 32'h0);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, ADDR_PRIORITY_A, 32'h2A);
      apb(1'b1, ADDR_PRIORITY_B, 32'h15);
      reg_check(ADDR_PRIORITY_A, 8'h2A);
      reg_check(ADDR_PRIORITY_B, 8'h15);
      apb(1'b1, ADDR_PRIORITY_A, 32'h00);
      apb(1'b1, ADDR_PRIORITY_B, 32'h00);
      apb(1'b1, ADDR_SOURCE_ENABLE_A, 32'hBF);
      apb(1'b1, ADDR_SOURCE_ENABLE_B, 32'h3F);
      reg_check(ADDR_SOURCE_ENABLE_A, 8'hBF);
      reg_check(ADDR_SOURCE_ENABLE_B, 8'h3F);
   endtask : reset_and_map

   task every_source;
      int s;
      for (s = 0; s < NUM_SRC; s++) begin
         fire(s, s == SRC_EXT0 || s == SRC_EXT1);
         vec(4'(s), (pin_of(s) == 7 || s >= SRC_EXT4 && pin_of(s) > 3) ? RESP_CLKS : 0);
      end
   endtask : every_source

   task edge_modes;
      apb(1'b1, ADDR_EDGE_SELECT, 32'h0F);
      fire(SRC_EXT0, 1'b0);
      vec(4'(SRC_EXT0), 0);
      fire(SRC_EXT1, 1'b0);
      vec(4'(SRC_EXT1), 0);
      fire(SRC_EXT2, 1'b0);
      vec(4'(SRC_EXT2), RESP_CLKS);
      fire(SRC_EXT3, 1'b0);
      vec(4'(SRC_EXT3), RESP_CLKS);
   endtask : edge_modes

   // equal level: polling order; raised pair: pre-empts the lower index
   task priority_pairs;
      ack_delay <= 8'd30;
      ev <= 5'b01001;
      @(posedge pclk);
      ev <= 5'h00;
      vec(4'(SRC_TMR0), 0);
      vec(4'(SRC_SER), 0);
      apb(1'b1, ADDR_PRIORITY_A, 32'h10);
      apb(1'b1, ADDR_PRIORITY_B, 32'h10);
      ev <= 5'b01001;
      @(posedge pclk);
      ev <= 5'h00;
      vec(4'(SRC_SER), 0);
      vec(4'(SRC_TMR0), 0);
      // raised request lands while the low vector still waits for its ack: served after it
      ev <= 5'b00001;
      @(posedge pclk);
      ev <= 5'h00;
      while (vector_valid !== 1'b1) @(posedge pclk);
      ev <= 5'b01000;
      @(posedge pclk);
      ev <= 5'h00;
      vec(4'(SRC_TMR0), 0);
      vec(4'(SRC_SER), 0);
      ack_delay <= 8'd0;
   endtask : priority_pairs

   // a masked source never vectors while its neighbour still does
   task masked_source;
      apb(1'b1, ADDR_SOURCE_ENABLE_A, 32'hB5);
      ev <= 5'b01011;
      @(posedge pclk);
      ev <= 5'h00;
      vec(4'(SRC_SER), 0);
      repeat (600) @(posedge pclk);
      `CHK("masked vector", 1'b0, vector_valid)
      reg_check(ADDR_REQUEST_FLAG, 8'h01);
   endtask : masked_source

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; pin_n = 7'h7F; ev = 5'h00; ack_delay = 8'd0;
      mismatches = 0; samples_checked = 0; cycles = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      reset_and_map();
      every_source();
      edge_modes();
      priority_pairs();
      masked_source();
      summarize();
   end
endmodule : paired_priority_interrupt_controller_bench

/* File: hw/irq_ctrl_pkg.sv */
// constants, register map and types of the paired priority interrupt controller
package irq_ctrl_pkg;
   // ****************************************
   // register map (index = printed location, byte address = 4 * index)
   // ****************************************
   localparam logic [7:0]  IDX_SOURCE_ENABLE_A = 8'hA8;
   localparam logic [7:0]  IDX_PRIORITY_A      = 8'hA9;
   localparam logic [7:0]  IDX_SOURCE_ENABLE_B = 8'hB8;
   localparam logic [7:0]  IDX_PRIORITY_B      = 8'hB9;
   localparam logic [7:0]  IDX_REQUEST_FLAG    = 8'hC0;
   localparam logic [7:0]  IDX_EDGE_SELECT     = 8'hC1;
   localparam logic [7:0]  IDX_SERVICE         = 8'hC2;
   localparam logic [11:0] ADDR_SOURCE_ENABLE_A = {2'b00, IDX_SOURCE_ENABLE_A, 2'b00};
   localparam logic [11:0] ADDR_PRIORITY_A      = {2'b00, IDX_PRIORITY_A, 2'b00};
   localparam logic [11:0] ADDR_SOURCE_ENABLE_B = {2'b00, IDX_SOURCE_ENABLE_B, 2'b00};
   localparam logic [11:0] ADDR_PRIORITY_B      = {2'b00, IDX_PRIORITY_B, 2'b00};
   localparam logic [11:0] ADDR_REQUEST_FLAG    = {2'b00, IDX_REQUEST_FLAG, 2'b00};
   localparam logic [11:0] ADDR_EDGE_SELECT     = {2'b00, IDX_EDGE_SELECT, 2'b00};
   localparam logic [11:0] ADDR_SERVICE         = {2'b00, IDX_SERVICE, 2'b00};

   // ****************************************
   // sources: index = 2*pair + member
   // ****************************************
   localparam int NUM_SRC   = 12;
   localparam int NUM_PAIRS = 6;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_ADC  = 1;
   localparam int SRC_TMR0 = 2;
   localparam int SRC_EXT2 = 3;
   localparam int SRC_EXT1 = 4;
   localparam int SRC_EXT3 = 5;
   localparam int SRC_TMR1 = 6;
   localparam int SRC_EXT4 = 7;
   localparam int SRC_SER  = 8;
   localparam int SRC_EXT5 = 9;
   localparam int SRC_TMR2 = 10;
   localparam int SRC_EXT6 = 11;

   // edge select register bits
   localparam int ES_EXT0_EDGE = 0;
   localparam int ES_EXT1_EDGE = 1;
   localparam int ES_EXT2_RISE = 2;
   localparam int ES_EXT3_RISE = 3;

   localparam logic [7:0]  RESET_BYTE     = 8'h00;
   localparam logic [15:0] VECTOR_BASE    = 16'h0003;
   localparam int          VECTOR_SHIFT   = 3;
   localparam logic [3:0]  NO_SOURCE      = 4'hF;
   // one machine cycle = 125 pclk periods (1000 ns); response delay in machine cycles
   localparam int          CLK_MHZ        = 125;
   localparam int          MCYCLE_NS      = 1000;
   localparam int          MCYCLE_CLKS    = (MCYCLE_NS * CLK_MHZ) / 1000;
   localparam int          RESP_MC        = 3;
   localparam int          RESP_CLKS      = RESP_MC * MCYCLE_CLKS;
   localparam logic [9:0]  RESP_CLKS_W    = 10'(RESP_CLKS);

   typedef enum logic [1:0] {IDLE_ST, WAIT_ST, PRESENT_ST} svc_state_type;
endpackage : irq_ctrl_pkg

/* File: hw/paired_priority_interrupt_controller.sv */
// paired priority interrupt controller with apb register access
// What this block does
// RQ1 - twelve sources grouped as six priority pairs
// RQ2 - each serviced source presents its own vector address to the core
// RQ3 - each source has its own enable; disabled sources never vector (enable checked in IDLE_ST and WAIT_ST; a presented vector stays until vector_ack)
// RQ4 - at least three machine cycles from recognition to service start
// RQ5 - external 0 and 1 trigger on low level or falling edge, selectable
// RQ6 - external 2 and 3 trigger on falling or rising edge, selectable
// RQ7 - external 4 to 6 trigger on rising edge only
// RQ8 - external 3 to 6 pins double as compare and capture pins
// RQ9 - priority per pair, four levels from one bit in each register
// RQ10 - priority registers at locations A9 and B9
// RQ11 - enable registers at locations A8 and B8, read and write
// RQ12 - added sources' pending flags in request register at C0
// RQ13 - higher level pre-empts lower; equal level uses fixed polling order
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module paired_priority_interrupt_controller
(
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       clk_en,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [11:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       ext_request_pin_0,
   input  wire logic                       ext_request_pin_1,
   input  wire logic                       ext_request_pin_2,
   input  wire logic                       ext_request_pin_3,
   input  wire logic                       ext_request_pin_4,
   input  wire logic                       ext_request_pin_5,
   input  wire logic                       ext_request_pin_6,
   input  wire logic                       timer0_event,
   input  wire logic                       timer1_event,
   input  wire logic                       timer2_event,
   input  wire logic                       serial_event,
   input  wire logic                       adc_event,
   input  wire logic                       vector_ack,
   input  wire logic                       service_done,
   output logic                            vector_valid,
   output logic      [15:0]                vector_addr,
   output logic      [3:0]                 vector_source
);
   import irq_ctrl_pkg::*;

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [6:0] pins_s;
   logic [6:0] pins_prev_q, pins_prev_d;

   // ext 3..6 share pins with compare/capture; detection only reads them
   pin_sync #(.W(7)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (clk_en),
      .async_in ({ext_request_pin_6, ext_request_pin_5, ext_request_pin_4,
                  ext_request_pin_3, ext_request_pin_2, ext_request_pin_1,
                  ext_request_pin_0}),   // RQ8
      .sync_out (pins_s)
   );

   // ****************************************
   // registers
   // ****************************************
   logic [7:0]  en_a_q, en_a_d, en_b_q, en_b_d;
   logic [7:0]  pri_a_q, pri_a_d, pri_b_q, pri_b_d;
   logic [7:0]  edge_q, edge_d;
   logic [11:0] pend_q, pend_d;
   logic [31:0] prdata_d;
   logic        pslverr_d, pready_d;

   // enable layout: reg a bits 0..5 = pair member 0, reg b bits 0..5 = member 1
   logic [11:0] src_en;
   logic [1:0]  pair_lvl [NUM_PAIRS];
   logic [11:0] trig;

   generate
      for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair   // RQ1
         assign src_en[2*p]     = en_a_q[p] & en_a_q[7];   // RQ3
         assign src_en[2*p + 1] = en_b_q[p] & en_a_q[7];   // RQ3
         assign pair_lvl[p]     = {pri_b_q[p], pri_a_q[p]}; // RQ9
      end
   endgenerate
   logic [6:0] pr, pf;
   assign pr = pins_s & ~pins_prev_q;
   assign pf = ~pins_s & pins_prev_q;

   // source triggers
   always_comb begin
      trig = '0;
      trig[SRC_EXT0] = edge_q[ES_EXT0_EDGE] ? pf[0] : ~pins_s[0]; // RQ5
      trig[SRC_EXT1] = edge_q[ES_EXT1_EDGE] ? pf[1] : ~pins_s[1]; // RQ5
      trig[SRC_EXT2] = edge_q[ES_EXT2_RISE] ? pr[2] : pf[2];      // RQ6
      trig[SRC_EXT3] = edge_q[ES_EXT3_RISE] ? pr[3] : pf[3];      // RQ6
      trig[SRC_EXT4] = pr[4];                                     // RQ7
      trig[SRC_EXT5] = pr[5];                                     // RQ7
      trig[SRC_EXT6] = pr[6];                                     // RQ7
      trig[SRC_TMR0] = timer0_event;
      trig[SRC_TMR1] = timer1_event;
      trig[SRC_TMR2] = timer2_event;
      trig[SRC_SER]  = serial_event;
      trig[SRC_ADC]  = adc_event;
   end

   // ****************************************
   // arbitration
   // ****************************************
   svc_state_type st_q, st_d;
   logic [9:0]    cnt_q, cnt_d;
   logic [3:0]    src_q, src_d;
   logic [1:0]    lvl_q, lvl_d;
   logic [3:0]    act_q, act_d;      // active level bitmap (nesting)
   logic [3:0]    win;
   logic [1:0]    win_lvl;
   logic [1:0]    cur_lvl;
   logic          win_ok, busy, ack_w;

   // highest pair level wins; lowest index first at equal level
   always_comb begin
      win = NO_SOURCE;
      win_lvl = 2'd0;
      win_ok = 1'b0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pend_q[i] && src_en[i] && (!win_ok || pair_lvl[i/2] >= win_lvl)) begin // RQ13
            win = 4'(i);
            win_lvl = pair_lvl[i/2];
            win_ok = 1'b1;
         end
      end
   end

   assign busy    = act_q != 4'h0;
   assign cur_lvl = act_q[3] ? 2'd3 : act_q[2] ? 2'd2 : act_q[1] ? 2'd1 : 2'd0;

   assign ack_w = (st_q == PRESENT_ST) && vector_ack;

   // service sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      src_d = src_q;
      lvl_d = lvl_q;
      act_d = act_q;
      if (service_done && busy) act_d[cur_lvl] = 1'b0;
      case (st_q)
         IDLE_ST: begin
            if (win_ok && (!busy || win_lvl > cur_lvl)) begin // RQ13
               st_d = WAIT_ST;
               src_d = win;
               lvl_d = win_lvl;
               cnt_d = RESP_CLKS_W - 10'd1;
            end
         end
         WAIT_ST: begin
            if (!src_en[src_q]) begin // RQ3
               st_d = IDLE_ST;
            end else if (cnt_q == 10'd0) begin
               st_d = PRESENT_ST; // RQ4
            end else begin
               cnt_d = cnt_q - 10'd1;
            end
         end
         PRESENT_ST: begin
            if (vector_ack) begin
               st_d = IDLE_ST;
               act_d[lvl_q] = 1'b1;
            end
         end
         default: st_d = IDLE_ST;
      endcase
   end

   // ****************************************
   // apb slave and flags
   // ****************************************
   logic wr_en;
   logic [7:0] wb;
   assign wr_en = psel && penable && pwrite;
   assign wb = pwdata[7:0];

   always_comb begin
      en_a_d = en_a_q;
      en_b_d = en_b_q;
      pri_a_d = pri_a_q;
      pri_b_d = pri_b_q;
      edge_d = edge_q;
      pend_d = pend_q;
      pins_prev_d = pins_s;
      pslverr_d = 1'b0;
      pready_d = psel && !penable;
      prdata_d = prdata;
      if (wr_en) begin
         case (paddr)
            ADDR_SOURCE_ENABLE_A: en_a_d = wb;            // RQ11
            ADDR_SOURCE_ENABLE_B: en_b_d = wb;            // RQ11
            ADDR_PRIORITY_A:      pri_a_d = wb;           // RQ10
            ADDR_PRIORITY_B:      pri_b_d = wb;           // RQ10
            ADDR_EDGE_SELECT:     edge_d = wb;
            ADDR_REQUEST_FLAG:    pend_d = {wb[5:0], pend_q[5:0]}; // RQ12
            ADDR_SERVICE:         pend_d[5:0] = wb[5:0];
            default: ;
         endcase
      end
      // hardware set wins over software clear; ack clears edge-type flag
      if (ack_w && !((src_q == SRC_EXT0 && !edge_q[ES_EXT0_EDGE]) ||
                     (src_q == SRC_EXT1 && !edge_q[ES_EXT1_EDGE]))) begin
         pend_d[src_q] = 1'b0; // RQ2
      end
      pend_d = pend_d | trig;
      if (!edge_q[ES_EXT0_EDGE]) pend_d[SRC_EXT0] = ~pins_s[0]; // RQ5
      if (!edge_q[ES_EXT1_EDGE]) pend_d[SRC_EXT1] = ~pins_s[1]; // RQ5
      if (psel && !penable) begin
         case (paddr)
            ADDR_SOURCE_ENABLE_A: prdata_d = {24'h0, en_a_q};
            ADDR_SOURCE_ENABLE_B: prdata_d = {24'h0, en_b_q};
            ADDR_PRIORITY_A:      prdata_d = {24'h0, pri_a_q & 8'h3F};
            ADDR_PRIORITY_B:      prdata_d = {24'h0, pri_b_q & 8'h3F};
            ADDR_EDGE_SELECT:     prdata_d = {24'h0, edge_q & 8'h0F};
            ADDR_REQUEST_FLAG:    prdata_d = {24'h0, 2'b00, pend_q[11:6]};
            ADDR_SERVICE:         prdata_d = {16'h0, 2'b00, pend_q[5:0], act_q, src_q};
            default: begin
               prdata_d = 32'h0000_0000;
               pslverr_d = 1'b1;
            end
         endcase
      end else if (psel && penable) begin
         pslverr_d = pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_a_q <= RESET_BYTE;
         en_b_q <= RESET_BYTE;
         pri_a_q <= RESET_BYTE;
         pri_b_q <= RESET_BYTE;
         edge_q <= RESET_BYTE;
         pend_q <= '0;
         pins_prev_q <= '1;
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         st_q <= IDLE_ST;
         cnt_q <= '0;
         src_q <= NO_SOURCE;
         lvl_q <= '0;
         act_q <= '0;
         vector_valid <= 1'b0;
         vector_addr <= '0;
         vector_source <= NO_SOURCE;
      end else if (clk_en) begin
         en_a_q <= en_a_d;
         en_b_q <= en_b_d;
         pri_a_q <= pri_a_d;
         pri_b_q <= pri_b_d;
         edge_q <= edge_d;
         pend_q <= pend_d;
         pins_prev_q <= pins_prev_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         src_q <= src_d;
         lvl_q <= lvl_d;
         act_q <= act_d;
         vector_valid <= (st_d == PRESENT_ST);
         vector_addr <= VECTOR_BASE + {src_d, 3'b000}; // RQ2
         vector_source <= src_d;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_vector_needs_enable: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      vector_valid |-> src_en[vector_source])
      else $error("vector from disabled source");
   a_vector_addr_map: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      vector_valid |-> vector_addr == VECTOR_BASE + {vector_source, 3'b000})
      else $error("vector address mismatch");
   a_resp_min_delay: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      (clk_en && st_q == IDLE_ST && st_d == WAIT_ST) ##1 clk_en[*8] |-> !vector_valid)
      else $error("vector too early");
   a_ext4_rise: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      (clk_en && pf[4] && !pend_q[SRC_EXT4] && !wr_en && !ack_w) |=> !pend_q[SRC_EXT4])
      else $error("falling edge set ext 4");
   a_ext0_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      (clk_en && !edge_q[ES_EXT0_EDGE] && !pins_s[0]) |=> pend_q[SRC_EXT0])
      else $error("low level not pending");
   a_preempt_level: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      (st_q == WAIT_ST && busy) |-> lvl_q > cur_lvl)
      else $error("no pre-emption by level");
endmodule : paired_priority_interrupt_controller

/* File: hw/pin_sync.sv */
// two-flop synchroniser bank for the external request pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 7
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // pins idle high; reset to high so no false edge at release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else if (ce) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : pin_sync
